// *** dcc_top.sv ***
// Dual comparator control: registers, input steering, edge events and wake request
//
// Overview of operation
// R1: Control on bit enables each comparator
// R2: Two-bit field steers the inverting input
// R3: Code 11 fixed reference, 00 the pin
// R4: Bit 2 picks pin or ladder reference
// R5: Result register bit0 comparator one, bit1 two
// R6: Output enable routes result to remappable pin
// R7: High when plus exceeds minus; optional inversion
// R8: Edge field 00 gives no events
// R9: 01 rising edge, 10 falling edge
// R10: 11 flags every output change
// R11: Selecting mode 11 sets the flag
// R12: Edges seen after polarity inversion
// R13: Flags sticky; software write one sets
// R14: Irq needs event, peripheral and global enables
// R15: Software tracks past results in mode 11
// R16: Enabled comparator runs and wakes in Sleep
// R17: Software turns comparators off before Sleep
// R18: Wake from Sleep keeps control contents
// R19: Reset loads control reset values, all off
// R20: Software sets chosen pin as analog input
// R21: Range bit picks one of two ranges
// R22: Four-bit level picks the ladder step
// R23: Outputs synchronised, edges against previous sample
// R24: Disabled comparator holds low, no events
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module dcc_top (
   input  wire logic        ref_clk,       // 125 MHz system clock
   input  wire logic        sys_rst,       // Asynchronous reset, active high
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB access phase
   input  wire logic        pwrite,        // APB write
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic             pready,        // APB ready
   output logic      [31:0] prdata,        // APB read data
   output logic             pslverr,       // APB error on unmapped address
   input  wire logic [1:0]  cmpRaw,        // Raw analog comparator outputs
   output logic      [1:0]  cmpEnable,     // Analog comparator power enables
   output logic      [1:0]  posSelLadder,  // Plus input takes ladder reference
   output logic      [3:0]  negSel,        // Minus input one-hot: pin,b,c,fixed (cmp1)
   output logic      [3:0]  negSel2,       // Minus input one-hot for comparator two
   output logic      [1:0]  pinOutEn,      // Remappable pin mux switched to comparator
   output logic      [1:0]  pinOut,        // Comparator level toward remappable pin
   output logic             ladderEnable,  // Ladder reference power
   output logic             ladderPinOut,  // Ladder reference drives its pin
   output logic             ladderRange,   // Range select: 1 low range from zero, coarser step
   output logic      [3:0]  ladderLevel,   // Ladder step
   output logic             irqReq,        // Interrupt request to core
   output logic             wakeReq        // Wake from Sleep request
);
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] ladder_q;
   logic       flag1_q;
   logic       flag2_q;
   logic [7:0] flagByte;
   logic [7:0] enable_q;
   logic [7:0] core_q;
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] prev_q;
   logic [1:0] result;
   logic [1:0] event_d;
   logic [1:0] anyArm;
   logic [1:0] flagSet;
   logic [1:0] irqSrc;
   logic       wrEn;
   logic       wrCtrl1;
   logic       wrCtrl2;
   logic       wrLadder;
   logic       wrFlag;
   logic       wrEnable;
   logic       wrCore;
   logic       rdHit;
   logic [7:0] rdByte;
   logic [7:0] ctrl [2];

   // A write lands at the edge that closes its access phase
   assign wrEn     = psel && penable && pwrite;
   assign wrCtrl1  = wrEn && paddr == dcc_pkg::CTRL1_OFS;
   assign wrCtrl2  = wrEn && paddr == dcc_pkg::CTRL2_OFS;
   assign wrLadder = wrEn && paddr == dcc_pkg::LADDER_OFS;
   assign wrFlag   = wrEn && paddr == dcc_pkg::FLAG_OFS;
   assign wrEnable = wrEn && paddr == dcc_pkg::ENABLE_OFS;
   assign wrCore   = wrEn && paddr == dcc_pkg::CORE_OFS;
   assign ctrl[0]  = ctrl1_q;
   assign ctrl[1]  = ctrl2_q;

   // Control registers; only reset and bus writes touch them, so Sleep and wake leave them alone
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl1_q <= dcc_pkg::CTRL_RST; // R19
      end else if (wrCtrl1) begin
         ctrl1_q <= pwdata[7:0]; // R18
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl2_q <= dcc_pkg::CTRL_RST; // R19
      end else if (wrCtrl2) begin
         ctrl2_q <= pwdata[7:0]; // R18
      end
   end

   // Reserved ladder bit kept at zero as the hardware expects
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ladder_q <= dcc_pkg::LADDER_RST; // R19
      end else if (wrLadder) begin
         ladder_q <= pwdata[7:0] & ~(8'h01 << dcc_pkg::LRSV_BIT);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q <= dcc_pkg::ENABLE_RST;
      end else if (wrEnable) begin
         enable_q <= pwdata[7:0];
      end
   end

   // Whole byte kept: the other enables belong to the core, not to this block
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_q <= dcc_pkg::CORE_RST;
      end else if (wrCore) begin
         core_q <= pwdata[7:0];
      end
   end

   // Second stage alone reads the first stage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 2'h0;
      end else begin
         sync1_q <= cmpRaw; // R23
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync2_q <= 2'h0;
      end else begin
         sync2_q <= sync1_q; // R23
      end
   end

   // Per comparator: polarity, gating, edge select, mode-11 arming
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      logic [1:0] edgeSel;
      logic       on;
      logic       rise;
      logic       fall;
      logic       edgeEv;
      assign on      = ctrl[i][dcc_pkg::ON_BIT]; // R1
      assign edgeSel = ctrl[i][dcc_pkg::EDGE_HI:dcc_pkg::EDGE_LO];
      // Inverting here makes it the same as swapping the inputs
      assign result[i] = on & (sync2_q[i] ^ ctrl[i][dcc_pkg::INV_BIT]); // R7 R12 R24
      assign rise = on & ~prev_q[i] & result[i]; // R23
      assign fall = on & prev_q[i] & ~result[i]; // R23
      always_comb begin
         case (dcc_pkg::dcc_edge_e'(edgeSel))
            dcc_pkg::EDGE_NONE: edgeEv = 1'b0; // R8
            dcc_pkg::EDGE_RISE: edgeEv = rise; // R9
            dcc_pkg::EDGE_FALL: edgeEv = fall; // R9
            dcc_pkg::EDGE_ANY:  edgeEv = rise | fall; // R10
            default:            edgeEv = 1'b0;
         endcase
      end
      assign event_d[i] = edgeEv;
      // Every write of code 11 arms the flag, even if the code was already 11
      assign anyArm[i] = (i == 0 ? wrCtrl1 : wrCtrl2)
         && pwdata[dcc_pkg::EDGE_HI:dcc_pkg::EDGE_LO] == dcc_pkg::EDGE_ANY; // R11
      assign posSelLadder[i] = ctrl[i][dcc_pkg::PSEL_BIT]; // R4
      assign pinOutEn[i]     = on & ctrl[i][dcc_pkg::OE_BIT]; // R6
      assign cmpEnable[i]    = on; // R1 R16
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_q <= 2'h0;
      end else begin
         prev_q <= result; // R23
      end
   end

   // Hardware set beats a software clear in the same cycle
   assign flagSet = event_d | anyArm; // R11 R13

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag1_q <= dcc_pkg::FLAG_RST[dcc_pkg::EV1_BIT];
      end else if (wrFlag) begin
         flag1_q <= pwdata[dcc_pkg::EV1_BIT] | flagSet[0]; // R13
      end else begin
         flag1_q <= flag1_q | flagSet[0]; // R13
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag2_q <= dcc_pkg::FLAG_RST[dcc_pkg::EV2_BIT];
      end else if (wrFlag) begin
         flag2_q <= pwdata[dcc_pkg::EV2_BIT] | flagSet[1]; // R13
      end else begin
         flag2_q <= flag2_q | flagSet[1]; // R13
      end
   end

   // Other bits of the flag register read as zero
   always_comb begin
      flagByte                   = dcc_pkg::FLAG_RST;
      flagByte[dcc_pkg::EV1_BIT] = flag1_q;
      flagByte[dcc_pkg::EV2_BIT] = flag2_q;
   end

   assign irqSrc[0] = flag1_q & enable_q[dcc_pkg::EV1_BIT];
   assign irqSrc[1] = flag2_q & enable_q[dcc_pkg::EV2_BIT];
   assign irqReq  = |irqSrc && core_q[dcc_pkg::PIE_BIT]
                    && core_q[dcc_pkg::GIE_BIT]; // R14
   // Wake needs only the source enable; the core decides what to run after it
   assign wakeReq = |irqSrc; // R16

   always_comb begin
      negSel  = 4'h0;
      negSel2 = 4'h0;
      negSel[ctrl1_q[dcc_pkg::NSEL_HI:dcc_pkg::NSEL_LO]]  = 1'b1; // R2 R3
      negSel2[ctrl2_q[dcc_pkg::NSEL_HI:dcc_pkg::NSEL_LO]] = 1'b1; // R2 R3
   end

   assign pinOut       = result; // R6
   assign ladderEnable = ladder_q[dcc_pkg::LREN_BIT];
   assign ladderPinOut = ladder_q[dcc_pkg::LROE_BIT];
   assign ladderRange  = ladder_q[dcc_pkg::RANGE_BIT]; // R21
   assign ladderLevel  = ladder_q[dcc_pkg::LVL_HI:dcc_pkg::LVL_LO]; // R22

   // Read mux; result register has no write path at all
   always_comb begin
      rdHit  = 1'b1;
      rdByte = 8'h00;
      case (paddr)
         dcc_pkg::CTRL1_OFS:  rdByte = ctrl1_q;
         dcc_pkg::CTRL2_OFS:  rdByte = ctrl2_q;
         dcc_pkg::RESULT_OFS: rdByte = {6'h00, result}; // R5
         dcc_pkg::LADDER_OFS: rdByte = ladder_q;
         dcc_pkg::FLAG_OFS:   rdByte = flagByte;
         dcc_pkg::ENABLE_OFS: rdByte = enable_q;
         dcc_pkg::CORE_OFS:   rdByte = core_q;
         default:             rdHit  = 1'b0;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rdHit;

   // Data output registered on the setup cycle, ready in the access cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h0, rdByte};
      end
   end
endmodule : dcc_top
`default_nettype wire

// *** dcc_pkg.sv ***
// Register map, field positions and reset values of the dual comparator control
package dcc_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0] CTRL1_OFS   = 8'h00;
   localparam logic [7:0] CTRL2_OFS   = 8'h04;
   localparam logic [7:0] RESULT_OFS  = 8'h08;
   localparam logic [7:0] LADDER_OFS  = 8'h0c;
   localparam logic [7:0] FLAG_OFS    = 8'h10;
   localparam logic [7:0] ENABLE_OFS  = 8'h14;
   localparam logic [7:0] CORE_OFS    = 8'h18;
   // Comparator control fields
   localparam int ON_BIT   = 7;
   localparam int OE_BIT   = 6;
   localparam int INV_BIT  = 5;
   localparam int EDGE_HI  = 4;
   localparam int EDGE_LO  = 3;
   localparam int PSEL_BIT = 2;
   localparam int NSEL_HI  = 1;
   localparam int NSEL_LO  = 0;
   // Ladder reference fields
   localparam int LREN_BIT  = 7;
   localparam int LROE_BIT  = 6;
   localparam int RANGE_BIT = 5;
   localparam int LRSV_BIT  = 4;
   localparam int LVL_HI    = 3;
   localparam int LVL_LO    = 0;
   // Flag and enable register bit positions, core enables
   localparam int EV1_BIT  = 5;
   localparam int EV2_BIT  = 6;
   localparam int PIE_BIT  = 6;
   localparam int GIE_BIT  = 7;
   // Reset values
   localparam logic [7:0] CTRL_RST   = 8'h1f;
   localparam logic [7:0] LADDER_RST = 8'h00;
   localparam logic [7:0] FLAG_RST   = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] CORE_RST   = 8'h00;
   localparam logic [7:0] RESULT_OFF = 8'h00;
   // Event edge codes
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_ANY  = 2'b11
   } dcc_edge_e;
   localparam logic [1:0] NSEL_PIN  = 2'b00;
   localparam logic [1:0] NSEL_FIXD = 2'b11;
endpackage : dcc_pkg

// *** dcc_asserts.sv ***
// Port checker for the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module dcc_asserts (
   input wire logic        ref_clk,      // Clock
   input wire logic        sys_rst,      // Reset
   input wire logic        psel,         // APB
   input wire logic        penable,      // APB
   input wire logic        pwrite,       // APB
   input wire logic [7:0]  paddr,        // APB
   input wire logic [31:0] pwdata,       // APB
   input wire logic [31:0] prdata,       // APB
   input wire logic        pslverr,      // APB
   input wire logic [1:0]  cmpEnable,    // Power
   input wire logic [1:0]  posSelLadder, // Plus select
   input wire logic [3:0]  negSel,       // Minus select
   input wire logic [3:0]  negSel2,      // Minus select two
   input wire logic        ladderPinOut, // Ladder pin
   input wire logic [1:0]  pinOutEn,     // Pin mux
   input wire logic [1:0]  pinOut,       // Pin level
   input wire logic        ladderEnable, // Ladder
   input wire logic        ladderRange,  // Ladder
   input wire logic [3:0]  ladderLevel,  // Ladder
   input wire logic        irqReq,       // Irq
   input wire logic        wakeReq       // Wake
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire acc = psel & penable;
   wire wrC = acc & pwrite & (paddr == dcc_pkg::CTRL1_OFS);
   wire wrL = acc & pwrite & (paddr == dcc_pkg::LADDER_OFS);
   wire wrC2 = acc & pwrite & (paddr == dcc_pkg::CTRL2_OFS);
   logic [1:0] coreEn_q;
   // Shadow of the two core enables, rebuilt from the bus alone
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         coreEn_q <= 2'b00;
      end else if (acc && pwrite && paddr == dcc_pkg::CORE_OFS) begin
         coreEn_q <= pwdata[dcc_pkg::GIE_BIT:dcc_pkg::PIE_BIT];
      end
   end
   property p_on; wrC |=> cmpEnable[0] == $past(pwdata[7]); endproperty
   a_on: assert property (p_on) else $error("enable bit not applied");
   property p_nsel; wrC |=> negSel == 4'h1 << $past(pwdata[1:0]); endproperty
   a_nsel: assert property (p_nsel) else $error("minus select wrong");
   property p_ch2;
      wrC2 |=> negSel2 == 4'h1 << $past(pwdata[1:0]) && cmpEnable[1] == $past(pwdata[7])
         && posSelLadder[1] == $past(pwdata[2]);
   endproperty
   a_ch2: assert property (p_ch2) else $error("comparator two controls wrong");
   property p_psel; wrC |=> posSelLadder[0] == $past(pwdata[2]); endproperty
   a_psel: assert property (p_psel) else $error("plus select wrong");
   property p_oe; wrC |=> pinOutEn[0] == ($past(pwdata[7]) & $past(pwdata[6])); endproperty
   a_oe: assert property (p_oe) else $error("pin mux wrong");
   property p_off; !cmpEnable[0] |-> !pinOut[0] && !pinOutEn[0]; endproperty
   a_off: assert property (p_off) else $error("off comparator drives pin");
   property p_irq; irqReq == (wakeReq && coreEn_q == 2'b11); endproperty
   a_irq: assert property (p_irq) else $error("irq without enabled flag");
   property p_lvl;
      wrL |=> ladderLevel == $past(pwdata[3:0]) && ladderRange == $past(pwdata[5])
         && ladderPinOut == $past(pwdata[6]) && ladderEnable == $past(pwdata[7]);
   endproperty
   a_lvl: assert property (p_lvl) else $error("ladder fields wrong");
   property p_res; acc && !pwrite && paddr == 8'h08 |-> prdata[31:2] == 30'h0; endproperty
   a_res: assert property (p_res) else $error("result upper bits set");
   property p_rst; disable iff (1'b0) sys_rst |-> cmpEnable == 2'b00 && !ladderEnable; endproperty
   a_rst: assert property (p_rst) else $error("reset leaves block on");
endmodule : dcc_asserts
`default_nettype wire

// *** dcc_analog.sv ***
// Analog side model: input pins, fixed and ladder references
`timescale 1ns/100ps
`default_nettype none
module dcc_analog (
   input  wire logic [1:0]  cmpEnable,    // Comparator power
   input  wire logic [1:0]  posSelLadder, // Plus from ladder
   input  wire logic [3:0]  negSel,       // Minus select one
   input  wire logic [3:0]  negSel2,      // Minus select two
   input  wire logic        ladderRange,  // Ladder range
   input  wire logic [3:0]  ladderLevel,  // Ladder step
   input  wire logic [23:0] vPinA,        // Plus pins, mV
   input  wire logic [23:0] vPinB,        // Minus pins, mV
   output logic      [1:0]  cmpRaw        // Raw outputs
);
   function automatic logic cmp(input logic on, pl, input logic [3:0] ns,
                                input logic [11:0] a, b, input int vl);
      int vp;
      int vm;
      vp = pl ? vl : int'(a);
      vm = ns[3] ? 600 : ns[0] ? int'(b) : 1650;
      return on && vp > vm;
   endfunction : cmp
   int vLad;
   always_comb begin
      vLad = ladderRange ? ladderLevel * 3300 / 24 : 825 + ladderLevel * 3300 / 32;
      cmpRaw[0] = cmp(cmpEnable[0], posSelLadder[0], negSel, vPinA[11:0], vPinB[11:0], vLad);
      cmpRaw[1] = cmp(cmpEnable[1], posSelLadder[1], negSel2, vPinA[23:12], vPinB[23:12], vLad);
   end
endmodule : dcc_analog
`default_nettype wire

// *** tb_dual_comparator_control.sv ***
// Self-checking bench for the dual comparator control block
`timescale 1ns/100ps
`default_nettype none
module tb_dual_comparator_control;
   logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic        ladderEnable, ladderPinOut, ladderRange, irqReq, wakeReq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  cmpRaw, cmpEnable, posSelLadder, pinOutEn, pinOut;
   logic [3:0]  negSel, negSel2, ladderLevel;
   logic [23:0] vPinA, vPinB;
   int          n_fail = 0, num_checks = 0, seed = 21, mreg[8];
   dcc_top u_dcc_top (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .pready       (pready),
      .prdata       (prdata),
      .pslverr      (pslverr),
      .cmpRaw       (cmpRaw),
      .cmpEnable    (cmpEnable),
      .posSelLadder (posSelLadder),
      .negSel       (negSel),
      .negSel2      (negSel2),
      .pinOutEn     (pinOutEn),
      .pinOut       (pinOut),
      .ladderEnable (ladderEnable),
      .ladderPinOut (ladderPinOut),
      .ladderRange  (ladderRange),
      .ladderLevel  (ladderLevel),
      .irqReq       (irqReq),
      .wakeReq      (wakeReq)
   );
   dcc_analog u_dcc_analog (
      .cmpEnable    (cmpEnable),
      .posSelLadder (posSelLadder),
      .negSel       (negSel),
      .negSel2      (negSel2),
      .ladderRange  (ladderRange),
      .ladderLevel  (ladderLevel),
      .vPinA        (vPinA),
      .vPinB        (vPinB),
      .cmpRaw       (cmpRaw)
   );
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request level from the model: a pending enabled flag, gated by the core enables
   function automatic logic [31:0] irqExp(input logic gate);
      logic pend;
      pend = (mreg[4] & mreg[5] & 32'h60) != 0;
      return {31'h0, pend && (!gate || mreg[6][7:6] == 2'b11)};
   endfunction : irqExp
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, {24'h0, d[7:0]});
      case (a[4:2])
         0, 1: begin
            mreg[a[4:2]] = d[7:0];
            if (d[4:3] == 2'b11) mreg[4] |= 32'h20 << a[2];
         end
         3: mreg[3] = d[7:0] & 8'hef;
         4: mreg[4] = d[7:0] & 8'h60;
         5, 6: mreg[a[4:2]] = d[7:0];
         default: ;
      endcase
   endtask : wr
   task automatic rdc(input logic [7:0] a, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, mreg[a[4:2]], rd);
   endtask : rdc
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   initial begin
      #100000;
      n_fail++;
      test_done;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, vPinA, vPinB} = '0;
      sys_rst = 1'b1;
      mreg = '{32'h1f, 32'h1f, 0, 0, 0, 0, 0, 0};
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 32; a += 4) rdc(a[7:0], "reset value");
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      repeat (40) begin
         wr(8'h00, $random(seed));
         wr(8'h04, $random(seed));
         wr(8'h0c, $random(seed));
         wr(8'h08, 32'hff);
         for (int a = 0; a < 16; a += 4) if (a != 8) rdc(a[7:0], "control");
      end
      $display("test control done");
      wr(8'h04, 32'h0);
      for (int m = 0; m < 8; m++) begin
         vPinA <= 24'd0;
         vPinB <= 24'd1000;
         wr(8'h00, 32'h80 | m * 8);
         repeat (6) @(posedge ref_clk);
         wr(8'h10, 32'h0);
         vPinA <= 24'd2000;
         repeat (6) @(posedge ref_clk);
         mreg[2] = {31'h0, ~m[2]};
         rdc(8'h08, "result");
         mreg[4] = (m[1:0] == 3 || m[1:0] == (m[2] ? 2 : 1)) ? 32'h20 : 0;
         rdc(8'h10, "rise flag");
         wr(8'h10, 32'h0);
         vPinA <= 24'd0;
         repeat (6) @(posedge ref_clk);
         mreg[4] = (m[1:0] == 3 || m[1:0] == (m[2] ? 1 : 2)) ? 32'h20 : 0;
         rdc(8'h10, "fall flag");
      end
      $display("test events done");
      wr(8'h10, 32'h20);
      wr(8'h14, 32'h20);
      wr(8'h18, 32'hc0);
      @(negedge ref_clk);
      chk("irq", irqExp(1'b1), {31'h0, irqReq});
      chk("wake", irqExp(1'b0), {31'h0, wakeReq});
      wr(8'h18, 32'h40);
      @(negedge ref_clk);
      chk("irq masked", irqExp(1'b1), {31'h0, irqReq});
      chk("wake masked", irqExp(1'b0), {31'h0, wakeReq});
      rdc(8'h10, "flag kept");
      $display("test irq done");
      wr(8'h00, 32'h0);
      mreg[2] = 0;
      rdc(8'h08, "result off");
      $display("test off done");
      test_done;
   end
endmodule : tb_dual_comparator_control
bind dcc_top dcc_asserts u_dcc_asserts (
   .ref_clk      (ref_clk),
   .sys_rst      (sys_rst),
   .psel         (psel),
   .penable      (penable),
   .pwrite       (pwrite),
   .paddr        (paddr),
   .pwdata       (pwdata),
   .prdata       (prdata),
   .pslverr      (pslverr),
   .cmpEnable    (cmpEnable),
   .posSelLadder (posSelLadder),
   .negSel       (negSel),
   .negSel2      (negSel2),
   .ladderPinOut (ladderPinOut),
   .pinOutEn     (pinOutEn),
   .pinOut       (pinOut),
   .ladderEnable (ladderEnable),
   .ladderRange  (ladderRange),
   .ladderLevel  (ladderLevel),
   .irqReq       (irqReq),
   .wakeReq      (wakeReq)
);
`default_nettype wire
